// *** tcwo_top.sv ***
// module: compare-match output unit with waveform-mode decode of an 8-bit timer
// What this block does
// - output mode field picks next match action
// - reset clears internal compare output register
// - nonzero output mode overrides port output value
// - direction bit still controls pin drive
// - override independent of waveform mode
// - compare output presettable before pin enable
// - mode zero: no change at match
// - reserved codes behave harmlessly
// - phase-correct channel B up/down set clear
// - compare equals TOP: act at TOP
// - control bits 3:2 read zero
// - three-bit waveform mode from two fields
// - modes 0 to 3 decode table
// - modes 4,6 reserved; 5 and 7 decoded
// - MAX is 0xFF, BOTTOM is 0x00
// - output mode changes act at once
// - output held across waveform mode changes
`timescale 1ns/100ps
`default_nettype none
module tcwo_top
   import tcwo_pkg::*;
#(
   parameter int W = 8
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,              // freezes all state when low
   input  wire logic        timer_tick_i,      // timer clock count enable
   input  wire logic [1:0]  waveform_mode_low_i,
   input  wire logic        waveform_mode_upper_i,
   input  wire logic [1:0]  mode_a_i,          // compare_output_mode of channel a
   input  wire logic [1:0]  mode_b_i,          // channel_b_output_mode
   input  wire logic [W-1:0] cmp_a_wr_i,       // compare_value_a written by software
   input  wire logic [W-1:0] cmp_b_wr_i,       // compare_value_b written by software
   input  wire logic        force_a_i,         // force_compare_strobe a
   input  wire logic        force_b_i,         // force_compare_strobe b
   input  wire logic        port_a_i,          // port output value of pin a
   input  wire logic        port_b_i,
   input  wire logic        dir_a_i,           // compare_pin_direction_bit a
   input  wire logic        dir_b_i,
   output logic             pin_a_o,
   output logic             pin_a_oe_o,
   output logic             pin_b_o,
   output logic             pin_b_oe_o,
   output logic [W-1:0]     count_o,
   output logic             overflow_flag_o,   // one-cycle pulse at flag point
   output logic [3:0]       ctrl_rd_o          // control register readback
);
   // elaboration check: the decode constants are 8 bits wide
   if (W != CNT_W) begin : g_bad_width
      $error("tcwo_top: only 8-bit counter supported");
   end

   logic [W-1:0] cnt_ff, nxt_cnt, compare_value_a_ff, nxt_compare_value_a, ocrb_ff, nxt_ocrb;
   logic         down_ff, nxt_down, oca_ff, nxt_oca, ocb_ff, nxt_ocb;
   logic         tov_ff, nxt_tov, pa_ff, pae_ff, pb_ff, pbe_ff;
   logic [3:0]   rd_ff;
   logic [2:0]   wm;
   logic [W-1:0] top;
   logic         pc_mode, pwm_mode, at_top, at_bot, upd_now;

   // waveform mode decode: TOP source and counting style
   always_comb begin
      wm       = {waveform_mode_upper_i, waveform_mode_low_i};
      pc_mode  = (wm == WM_PC_FF) || (wm == WM_PC_A);
      pwm_mode = pc_mode || (wm == WM_FAST_FF) || (wm == WM_FAST_A);
      // reserved modes count as normal mode
      top      = (wm == WM_CTC || wm == WM_PC_A || wm == WM_FAST_A) ? compare_value_a_ff : CNT_MAX;
      at_top   = (cnt_ff == top);
      at_bot   = (cnt_ff == CNT_BOTTOM);
      upd_now  = !pwm_mode || at_top;
   end

   // action of one channel on a match; pc selects up/down coding
   function automatic logic next_out(input logic cur, input logic [1:0] m, input logic pwm,
                                     input logic pc, input logic dn);
      logic r;
      r = cur;
      if (m == MODE_OFF) r = cur;
      else if (pc) r = (m == MODE_TOGGLE) ? cur : (dn ? (m == MODE_CLEAR) : (m == MODE_SET));
      else if (m == MODE_TOGGLE) r = pwm ? cur : !cur;
      else r = (m == MODE_SET);
      return r;
   endfunction : next_out

   // counter, compare buffers, compare output registers
   always_comb begin
      nxt_cnt  = cnt_ff;
      nxt_down = down_ff;
      nxt_tov  = 1'b0;
      nxt_compare_value_a = upd_now ? cmp_a_wr_i : compare_value_a_ff;
      nxt_ocrb = upd_now ? cmp_b_wr_i : ocrb_ff;
      nxt_oca  = oca_ff;
      nxt_ocb  = ocb_ff;
      if (timer_tick_i) begin
         if (pc_mode) begin
            // bottom wins when TOP is zero, so the counter never wraps below zero
            if (at_bot) nxt_down = 1'b0;
            else if (at_top) nxt_down = 1'b1;
            nxt_cnt = (!at_bot && (at_top || down_ff)) ? cnt_ff - 1'b1 : cnt_ff + 1'b1;
            if (at_bot && down_ff) nxt_tov = 1'b1;
         end else begin
            nxt_cnt = at_top ? CNT_BOTTOM : cnt_ff + 1'b1;
            nxt_tov = (wm == WM_FAST_A) ? at_top : (cnt_ff == CNT_MAX);
         end
         // channel a match
         if (cnt_ff == compare_value_a_ff)
            nxt_oca = next_out(oca_ff, mode_a_i, pwm_mode, pc_mode, down_ff);
         // channel b: in phase-correct mode a match at TOP acts at TOP
         if (pc_mode && ocrb_ff == top && mode_b_i[1]) begin
            if (at_top) nxt_ocb = (mode_b_i == MODE_SET);
         end else if (cnt_ff == ocrb_ff)
            nxt_ocb = next_out(ocb_ff, mode_b_i, pwm_mode, pc_mode, down_ff);
         if (!pwm_mode && cnt_ff != ocrb_ff && wm != WM_CTC && at_top) nxt_ocb = nxt_ocb;
      end
      // forced compare in non-PWM modes presets the output
      if (force_a_i && !pwm_mode) nxt_oca = next_out(oca_ff, mode_a_i, 1'b0, 1'b0, 1'b0);
      if (force_b_i && !pwm_mode) nxt_ocb = next_out(ocb_ff, mode_b_i, 1'b0, 1'b0, 1'b0);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_ff  <= CNT_BOTTOM;
         down_ff <= 1'b0;
         tov_ff  <= 1'b0;
         compare_value_a_ff <= CMP_RST;
         ocrb_ff <= CMP_RST;
         oca_ff  <= OUT_RST;
         ocb_ff  <= OUT_RST;
      end else if (ce_i) begin
         cnt_ff  <= nxt_cnt;
         down_ff <= nxt_down;
         tov_ff  <= nxt_tov;
         compare_value_a_ff <= nxt_compare_value_a;
         ocrb_ff <= nxt_ocrb;
         oca_ff  <= nxt_oca;
         ocb_ff  <= nxt_ocb;
      end
   end

   // pin mux: override depends on mode field only, direction from port
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pa_ff  <= 1'b0;
         pae_ff <= 1'b0;
         pb_ff  <= 1'b0;
         pbe_ff <= 1'b0;
         rd_ff  <= 4'h0;
      end else if (ce_i) begin
         pa_ff  <= (mode_a_i != MODE_OFF) ? nxt_oca : port_a_i;
         pb_ff  <= (mode_b_i != MODE_OFF) ? nxt_ocb : port_b_i;
         pae_ff <= dir_a_i;
         pbe_ff <= dir_b_i;
         rd_ff  <= {2'b00, waveform_mode_low_i} & CTRL_RES_MASK;
      end
   end

   assign pin_a_o         = pa_ff;
   assign pin_a_oe_o      = pae_ff;
   assign pin_b_o         = pb_ff;
   assign pin_b_oe_o      = pbe_ff;
   assign count_o         = cnt_ff;
   assign overflow_flag_o = tov_ff;
   assign ctrl_rd_o       = rd_ff;

   // assertions
   property p_reset_clear;
      @(posedge clk_i) rst_i |=> (oca_ff == 1'b0 && ocb_ff == 1'b0);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("compare output not cleared");
   property p_override;
      @(posedge clk_i) disable iff (rst_i) (ce_i && mode_a_i != MODE_OFF) |=> (pin_a_o == oca_ff);
   endproperty
   a_override: assert property (p_override) else $error("pin a not overridden");
   property p_port;
      @(posedge clk_i) disable iff (rst_i) (ce_i && mode_a_i == MODE_OFF) |=> (pin_a_o == $past(port_a_i));
   endproperty
   a_port: assert property (p_port) else $error("pin a not from port");
   property p_dir;
      @(posedge clk_i) disable iff (rst_i) ce_i |=> (pin_b_oe_o == $past(dir_b_i));
   endproperty
   a_dir: assert property (p_dir) else $error("direction not followed");
   property p_off_hold;
      @(posedge clk_i) disable iff (rst_i) (ce_i && mode_a_i == MODE_OFF) |=> $stable(oca_ff);
   endproperty
   a_off_hold: assert property (p_off_hold) else $error("output changed in mode zero");
   property p_rdzero;
      @(posedge clk_i) disable iff (rst_i) ctrl_rd_o[3:2] == 2'b00;
   endproperty
   a_rdzero: assert property (p_rdzero) else $error("reserved bits nonzero");
   property p_bounds;
      @(posedge clk_i) disable iff (rst_i) (ce_i && !pwm_mode && !pc_mode && at_top && timer_tick_i)
         |=> (cnt_ff == CNT_BOTTOM);
   endproperty
   a_bounds: assert property (p_bounds) else $error("counter did not wrap at TOP");
   property p_buffer;
      @(posedge clk_i) disable iff (rst_i) (ce_i && pwm_mode && !at_top) |=> $stable(ocrb_ff);
   endproperty
   a_buffer: assert property (p_buffer) else $error("compare updated off update point");
   property p_clear_up;
      @(posedge clk_i) disable iff (rst_i)
         (ce_i && timer_tick_i && pc_mode && !down_ff && mode_a_i == MODE_CLEAR && cnt_ff == compare_value_a_ff)
         |=> !oca_ff;
   endproperty
   a_clear_up: assert property (p_clear_up) else $error("no clear on up match");
   // channel b with compare at TOP acts at TOP
   property p_top_act;
      @(posedge clk_i) disable iff (rst_i)
         (ce_i && timer_tick_i && pc_mode && at_top && ocrb_ff == top && mode_b_i == MODE_SET) |=> ocb_ff;
   endproperty
   a_top_act: assert property (p_top_act) else $error("channel b not set at TOP");
   // phase-correct overflow flag at bottom
   property p_bot_flag;
      @(posedge clk_i) disable iff (rst_i) (ce_i && timer_tick_i && pc_mode && at_bot && down_ff)
         |=> overflow_flag_o;
   endproperty
   a_bot_flag: assert property (p_bot_flag) else $error("no flag at bottom");
   c_top_b: cover property (@(posedge clk_i) pc_mode && at_top && ocrb_ff == top && mode_b_i[1]);
   c_pc: cover property (@(posedge clk_i) pc_mode && at_top && timer_tick_i);
   c_fast: cover property (@(posedge clk_i) overflow_flag_o && wm == WM_FAST_A);
   c_force: cover property (@(posedge clk_i) force_a_i && !pwm_mode);
endmodule : tcwo_top
`default_nettype wire

// *** tcwo_pkg.sv ***
// package: constants and types for the timer compare waveform output block
package tcwo_pkg;
   localparam int          CNT_W        = 8;
   localparam logic [7:0]  CNT_MAX      = 8'hFF;      // counter maximum
   localparam logic [7:0]  CNT_BOTTOM   = 8'h00;      // counter bottom
   localparam logic [7:0]  CMP_RST      = 8'h00;      // compare value reset
   localparam logic        OUT_RST      = 1'b0;       // compare_output reset
   localparam logic [1:0]  MODE_OFF     = 2'h0;       // no action, port drives pin
   localparam logic [1:0]  MODE_TOGGLE  = 2'h1;
   localparam logic [1:0]  MODE_CLEAR   = 2'h2;
   localparam logic [1:0]  MODE_SET     = 2'h3;
   localparam logic [2:0]  WM_NORMAL    = 3'h0;
   localparam logic [2:0]  WM_PC_FF     = 3'h1;
   localparam logic [2:0]  WM_CTC       = 3'h2;
   localparam logic [2:0]  WM_FAST_FF   = 3'h3;
   localparam logic [2:0]  WM_RES4      = 3'h4;
   localparam logic [2:0]  WM_PC_A      = 3'h5;
   localparam logic [2:0]  WM_RES6      = 3'h6;
   localparam logic [2:0]  WM_FAST_A    = 3'h7;
   localparam logic [3:0]  CTRL_RES_MASK = 4'h3;      // bits 3:2 read zero
endpackage : tcwo_pkg

// *** tcwo_port_pin.sv ***
// port pin model: resolves the pin level from the block's override value and direction
`timescale 1ns/100ps
`default_nettype none
module tcwo_port_pin (
   input  wire logic clk_i,
   input  wire logic drv_i,   // value driven by the block
   input  wire logic oe_i,    // direction bit selects output
   output var  logic pad_o    // level seen on the pin
);
   logic last_ff = 1'b0;
   // remember the last driven level so a released pin never shows it
   always_ff @(posedge clk_i) if (oe_i) last_ff <= drv_i;
   // undriven pin floats: show the inverse of the last driven level
   always_comb pad_o = oe_i ? drv_i : ~last_ff;
endmodule : tcwo_port_pin
`default_nettype wire

// *** timer_compare_waveform_output_test.sv ***
// self-checking bench for the compare output unit and the waveform mode decode
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module timer_compare_waveform_output_test;
   import tcwo_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, tick = 1'b0;
   logic [2:0]  wm = 3'h0;
   logic [1:0]  mode [2] = '{2'h0, 2'h0};
   logic [7:0]  cmp  [2] = '{8'h00, 8'h00};
   logic        frc  [2] = '{1'b0, 1'b0};
   logic        port [2] = '{1'b0, 1'b0};
   logic        dir  [2] = '{1'b0, 1'b0};
   logic        pin [2], oe [2], pad [2], flag;
   logic [7:0]  count;
   logic [3:0]  ctrl;
   logic [31:0] rnd = 32'h0001_1EE2;
   logic [2:0]  order [8] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6, 3'h1, 3'h5, 3'h7};
   int          mismatches = 0, n_compared = 0;
   tcwo_top #(.W(8)) i_tcwo_top (.clk_i(clk), .rst_i(rst), .ce_i(ce), .timer_tick_i(tick),
      .waveform_mode_low_i(wm[1:0]), .waveform_mode_upper_i(wm[2]), .mode_a_i(mode[0]), .mode_b_i(mode[1]),
      .cmp_a_wr_i(cmp[0]), .cmp_b_wr_i(cmp[1]), .force_a_i(frc[0]), .force_b_i(frc[1]),
      .port_a_i(port[0]), .port_b_i(port[1]), .dir_a_i(dir[0]), .dir_b_i(dir[1]),
      .pin_a_o(pin[0]), .pin_a_oe_o(oe[0]), .pin_b_o(pin[1]), .pin_b_oe_o(oe[1]),
      .count_o(count), .overflow_flag_o(flag), .ctrl_rd_o(ctrl));
   tcwo_port_pin i_tcwo_port_pin_a (.clk_i(clk), .drv_i(pin[0]), .oe_i(oe[0]), .pad_o(pad[0]));
   tcwo_port_pin i_tcwo_port_pin_b (.clk_i(clk), .drv_i(pin[1]), .oe_i(oe[1]), .pad_o(pad[1]));
   // free-running clock, 20 ns period
   always #10 clk = ~clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // expected TOP of each waveform mode; reserved modes behave as normal
   function automatic logic [7:0] exp_top(input logic [2:0] m, input logic [7:0] ca);
      return (m == WM_CTC || m == WM_PC_A || m == WM_FAST_A) ? ca : CNT_MAX;
   endfunction : exp_top
   // overflow pulses over 600 ticks from reset, -1 where not checked
   function automatic int exp_flags(input logic [2:0] m);
      return (m == WM_CTC) ? 0 : (m[0] && m != WM_FAST_FF) ? -1 : 2;
   endfunction : exp_flags
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask : step
   task automatic pulse(input int ch);
      frc[ch] = 1'b1;
      step(1);
      frc[ch] = 1'b0;
      step(2);
   endtask : pulse
   // preset, override, hold and force handling of one channel with the counter stopped
   task automatic chan_test(input int ch);
      wm = WM_NORMAL;
      cmp[ch] = 8'h80;
      port[ch] = rnd[3];
      mode[ch] = MODE_SET;
      pulse(ch);
      `CHK(oe[ch], 1'b0)
      dir[ch] = 1'b1;
      step(2);
      `CHK(pad[ch], 1'b1)
      mode[ch] = MODE_OFF;
      pulse(ch);
      `CHK(pad[ch], port[ch])
      mode[ch] = MODE_TOGGLE;
      step(2);
      `CHK(pad[ch], 1'b1)
      pulse(ch);
      `CHK(pad[ch], 1'b0)
      wm = WM_FAST_A;
      mode[ch] = MODE_SET;
      step(2);
      `CHK(pad[ch], 1'b0)
      pulse(ch);
      `CHK(pad[ch], 1'b0)
      $display("test channel %0d done", ch);
   endtask : chan_test
   // peak count against TOP, number of overflow pulses, readback and ce freeze of one waveform mode
   task automatic run_mode(input logic [2:0] m);
      logic [7:0] peak;
      int         flags;
      int         ticks;
      rnd = lfsr(rnd);
      cmp[0] = 8'h40 + {1'b0, rnd[6:0]};
      cmp[1] = rnd[15:8];
      wm = m;
      step(1);
      rst = 1'b1;
      step(1);
      rst = 1'b0;
      peak = 8'h00;
      flags = 0;
      ticks = 0;
      while (ticks < 600) begin
         rnd = lfsr(rnd);
         tick = rnd[0] | rnd[5];
         ticks += tick;
         step(1);
         if (count > peak) peak = count;
         flags += flag;
      end
      tick = 1'b0;
      step(2);
      `CHK(peak, exp_top(m, cmp[0]))
      if (exp_flags(m) >= 0) `CHK(flags, exp_flags(m))
      `CHK(ctrl, {2'b00, m[1:0]})
      ce = 1'b0;
      peak = count;
      tick = 1'b1;
      step(4);
      `CHK(count, peak)
      ce = 1'b1;
      tick = 1'b0;
      $display("test waveform mode %0d done", m);
   endtask : run_mode
   task automatic complete_run();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   // watchdog: far beyond the few thousand cycles the tests need
   initial begin
      #(20 * 40000);
      mismatches++;
      complete_run();
   end
   // main sequence: reset, both channels, then every waveform mode
   initial begin
      step(5);
      rst = 1'b0;
      step(1);
      `CHK({pin[0], oe[0], pin[1], oe[1], count, flag}, 13'h0000)
      $display("test reset done");
      chan_test(0);
      chan_test(1);
      foreach (order[i]) run_mode(order[i]);
      complete_run();
   end
endmodule : timer_compare_waveform_output_test
`default_nettype wire
